// ===== verif/board_config_transfer_regs_tb_top.sv
// Self-checking bench for the configuration transfer registers
`timescale 1ns/1ps
module board_config_transfer_regs_tb_top;
    import cfg_xfer_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o, mgmt_rdata_i, config_output_data_o;
    logic avs_waitrequest_o, mgmt_req_o, mgmt_ack_i, mgmt_done_i;
    logic mgmt_fail_i, mgmt_rdata_we_i, transfer_direction_o, irq_o;
    logic [5:0] function_o;
    logic [11:0] device_o;
    logic fail_sel = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [31:0] rval = 32'h0;
    logic [31:0] seed = 32'he71e9d71;
    logic [31:0] exp_q[$];
    int fails = 0;
    int check_count = 0;

    board_config_transfer_regs board_config_transfer_regs_i (
        .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .mgmt_req_o(mgmt_req_o),
        .mgmt_ack_i(mgmt_ack_i), .mgmt_done_i(mgmt_done_i),
        .mgmt_fail_i(mgmt_fail_i), .mgmt_rdata_we_i(mgmt_rdata_we_i),
        .mgmt_rdata_i(mgmt_rdata_i),
        .transfer_direction_o(transfer_direction_o),
        .function_o(function_o), .device_o(device_o),
        .config_output_data_o(config_output_data_o), .irq_o(irq_o));

    mgmt_ctrl_model mgmt_ctrl_model_i (
        .clk_i(clk_i), .nrst_i(nrst_i), .req_i(mgmt_req_o),
        .dir_i(transfer_direction_o), .fail_sel_i(fail_sel),
        .delay_i(dly), .rval_i(rval), .ack_o(mgmt_ack_i),
        .done_o(mgmt_done_i), .fail_o(mgmt_fail_i),
        .rdata_we_o(mgmt_rdata_we_i), .rdata_o(mgmt_rdata_i));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= ~w;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (n >= 20) begin
            fails++;
            finish_test();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask

    // Read data monitor against the oldest noted expectation
    always @(posedge clk_i) begin
        if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
            if (exp_q.size() > 0) begin
                chk(avs_readdata_o, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin : main
        logic [31:0] ctl, v, od;
        logic dir, fl;
        int n;
        repeat (5) @(posedge clk_i);
        chk({29'h0, avs_waitrequest_o, mgmt_req_o, irq_o}, 32'h4);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 7; i++) rd(5'(i * 4), 32'h0);
        wr(5'h18, rnd());
        rd(5'h18, 32'h0);
        $display("test reset done");
        v = rnd();
        wr(OFF_OUTPUT_DATA, v);
        ctl = rnd();
        bus(1'b1, OFF_OUTPUT_DATA, ctl, 4'h3);
        v = {v[31:16], ctl[15:0]};
        rd(OFF_OUTPUT_DATA, v);
        chk(config_output_data_o, v);
        wr(OFF_IRQ_MASK, 32'h2);
        rd(OFF_IRQ_MASK, 32'h2);
        $display("test data done");
        for (int i = 0; i < 4; i++) begin
            dir = i[0];
            fl = (i == 3);
            fail_sel <= fl;
            ctl = rnd();
            dly <= ctl[3:0];
            rval <= rnd();
            od = rnd();
            if (dir) begin
                wr(OFF_OUTPUT_DATA, od);
            end
            ctl = {1'b1, dir, 4'h0, FUNC_CLOCK_GEN, 8'h00, 12'(i % 3)};
            wr(OFF_CONTROL, ctl);
            @(posedge clk_i);
            #1;
            chk({31'h0, mgmt_req_o}, 32'h1);
            n = 0;
            while (mgmt_done_i !== 1'b1 && n < 40) begin
                @(posedge clk_i);
                n++;
            end
            if (n >= 40) begin
                fails++;
                finish_test();
            end
            repeat (3) @(posedge clk_i);
            if (dir) begin
                chk(config_output_data_o, od);
            end
            chk(32'({transfer_direction_o, function_o, device_o}),
                32'({dir, FUNC_CLOCK_GEN, 12'(i % 3)}));
            chk({31'h0, irq_o}, {31'h0, fl});
            rd(OFF_STATUS, {30'h0, fl, 1'b1});
            rd(OFF_CONTROL, ctl & 32'h43f0_0fff);
            if (!dir) begin
                rd(OFF_RETURN_DATA, rval);
                v = rval;
            end
            rd(OFF_IRQ_STATUS, {30'h0, fl, 1'b1});
            wr(OFF_IRQ_STATUS, 32'h3);
            rd(OFF_IRQ_STATUS, 32'h0);
        end
        $display("test transfers done");
        wr(OFF_STATUS, 32'h0);
        rd(OFF_STATUS, 32'h3);
        wr(OFF_RETURN_DATA, ~v);
        rd(OFF_RETURN_DATA, v);
        wr(OFF_CONTROL, 32'h0);
        rd(OFF_STATUS, 32'h0);
        @(posedge clk_i);
        #1;
        chk({31'h0, mgmt_req_o}, 32'h0);
        $display("test clear done");
        finish_test();
    end
endmodule

// ===== verif/mgmt_ctrl_model.sv
// Behavioural board management controller answering transfer requests
`timescale 1ns/1ps
module mgmt_ctrl_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Request from the register block
    input wire logic req_i,
    input wire logic dir_i,
    // Scenario knobs
    input wire logic fail_sel_i,
    input wire logic [3:0] delay_i,
    input wire logic [31:0] rval_i,
    // Answers
    output logic ack_o,
    output logic done_o,
    output logic fail_o,
    output logic rdata_we_o,
    output logic [31:0] rdata_o
);
    initial begin
        ack_o = 1'b0;
        done_o = 1'b0;
        fail_o = 1'b1;
        rdata_we_o = 1'b0;
        rdata_o = 32'h0;
        forever begin
            @(posedge clk_i);
            if (nrst_i === 1'b1 && req_i === 1'b1) begin
                ack_o <= 1'b1;
                @(posedge clk_i);
                ack_o <= 1'b0;
                repeat (delay_i) @(posedge clk_i);
                if (dir_i == 1'b0) begin
                    rdata_we_o <= 1'b1;
                    rdata_o <= rval_i;
                    @(posedge clk_i);
                    rdata_we_o <= 1'b0;
                    rdata_o <= ~rval_i;
                end
                done_o <= 1'b1;
                fail_o <= fail_sel_i;
                @(posedge clk_i);
                done_o <= 1'b0;
                fail_o <= ~fail_sel_i;
            end
        end
    end
endmodule

// ===== verilog/board_config_transfer_regs.sv
// Configuration transfer control and status registers, Avalon-MM slave
`timescale 1ns/1ps
module board_config_transfer_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Avalon-MM slave
    input wire logic [cfg_xfer_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [cfg_xfer_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [cfg_xfer_pkg::BE_W-1:0] avs_byteenable_i,
    output logic [cfg_xfer_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Board management controller side
    output logic mgmt_req_o,
    input wire logic mgmt_ack_i,
    input wire logic mgmt_done_i,
    input wire logic mgmt_fail_i,
    input wire logic mgmt_rdata_we_i,
    input wire logic [cfg_xfer_pkg::DATA_W-1:0] mgmt_rdata_i,
    // Transfer parameters towards the controller
    output logic transfer_direction_o,
    output logic [cfg_xfer_pkg::CTRL_FUNC_W-1:0] function_o,
    output logic [cfg_xfer_pkg::CTRL_DEV_W-1:0] device_o,
    output logic [cfg_xfer_pkg::DATA_W-1:0] config_output_data_o,
    // Interrupt to software
    output logic irq_o
);
    import cfg_xfer_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops

    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, answer in the second

    bus_state_t bus_q;
    bus_state_t bus_d;
    logic wait_q;
    logic wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic acc_wr;
    logic wr_ctrl;
    logic wr_out;
    logic wr_mask;
    logic wr_istat;
    logic wr_stat;
    logic [31:0] wmask;

    always_comb begin
        bus_d = bus_q;
        wait_d = 1'b1;
        case (bus_q)
            BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    bus_d = BUS_ANSWER;
                    wait_d = 1'b0;
                end
            end
            BUS_ANSWER: begin
                bus_d = BUS_IDLE;
            end
            default: begin
                bus_d = BUS_IDLE;
            end
        endcase
    end

    // Write takes effect at the edge where waitrequest is sampled low
    assign acc_wr = avs_write_i && (bus_q == BUS_ANSWER);
    assign wr_ctrl = acc_wr && (avs_address_i == OFF_CONTROL);
    assign wr_out = acc_wr && (avs_address_i == OFF_OUTPUT_DATA);
    assign wr_mask = acc_wr && (avs_address_i == OFF_IRQ_MASK);
    assign wr_istat = acc_wr && (avs_address_i == OFF_IRQ_STATUS);
    assign wr_stat = acc_wr && (avs_address_i == OFF_STATUS);
    assign wmask = be_mask(avs_byteenable_i);

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    logic dir_q;
    logic dir_d;
    logic [5:0] func_q;
    logic [5:0] func_d;
    logic [11:0] dev_q;
    logic [11:0] dev_d;
    logic [31:0] out_q;
    logic [31:0] out_d;
    logic [31:0] rtn_q;
    logic [31:0] rtn_d;
    logic [EVT_W-1:0] mask_q;
    logic [EVT_W-1:0] mask_d;
    logic req_q;
    logic req_d;
    logic done_q;
    logic done_d;
    logic err_q;
    logic err_d;
    logic start_wr;
    logic [31:0] ctrl_new;
    logic [31:0] ctrl_mrg;

    assign ctrl_new = be_merge(32'h0, avs_writedata_i, avs_byteenable_i);
    // Stored control fields in their word positions, merged per byte lane
    assign ctrl_mrg = be_merge({1'b0, dir_q, 4'h0, func_q, 8'h0, dev_q},
                               avs_writedata_i, avs_byteenable_i);
    assign start_wr = wr_ctrl && wmask[CTRL_START_BIT]
                      && ctrl_new[CTRL_START_BIT];

    always_comb begin
        dir_d = dir_q;
        func_d = func_q;
        dev_d = dev_q;
        if (wr_ctrl) begin
            // Reserved bits 29..26 and 19..12 are not stored
            dir_d = ctrl_mrg[CTRL_DIR_BIT];
            func_d = ctrl_mrg[CTRL_FUNC_LSB +: CTRL_FUNC_W];
            dev_d = ctrl_mrg[CTRL_DEV_LSB +: CTRL_DEV_W];
        end
        out_d = wr_out ? be_merge(out_q, avs_writedata_i,
                                  avs_byteenable_i) : out_q;
        // Only the controller loads returned data
        rtn_d = mgmt_rdata_we_i ? mgmt_rdata_i : rtn_q;
        mask_d = wr_mask ? ctrl_new[EVT_W-1:0] : mask_q;
        // Request held until the controller takes it, set wins
        req_d = start_wr || (req_q && !mgmt_ack_i);
        // Control write clears flags; end of transfer sets done, and error only on a failure
        // No software write path into the status flags
        done_d = mgmt_done_i || (done_q && !wr_ctrl);
        err_d = (mgmt_done_i && mgmt_fail_i)
                || (err_q && !wr_ctrl);
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bus_q <= BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= DATA_RST;
            dir_q <= DIR_RST;
            func_q <= FUNC_RST;
            dev_q <= DEV_RST;
            out_q <= DATA_RST;
            rtn_q <= DATA_RST;
            mask_q <= EVT_RST;
            req_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            bus_q <= bus_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            dir_q <= dir_d;
            func_q <= func_d;
            dev_q <= dev_d;
            out_q <= out_d;
            rtn_q <= rtn_d;
            mask_q <= mask_d;
            req_q <= req_d;
            done_q <= done_d;
            err_q <= err_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events

    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] iclr;
    logic [EVT_W-1:0] istat;

    always_comb begin
        evt = '0;
        evt[EVT_DONE] = mgmt_done_i;
        evt[EVT_ERROR] = mgmt_done_i && mgmt_fail_i;
        iclr = wr_istat ? ctrl_new[EVT_W-1:0] : '0;
    end

    irq_event_bank u_irq (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .evt_i(evt),
        .clr_i(iclr),
        .mask_i(mask_q),
        .status_o(istat),
        .irq_o(irq_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the wait cycle; unmapped reads return zero

    always_comb begin
        rdata_d = rdata_q;
        if (avs_read_i && (bus_q == BUS_IDLE)) begin
            rdata_d = 32'h0;
            case (avs_address_i)
                OFF_RETURN_DATA: rdata_d = rtn_q;
                OFF_OUTPUT_DATA: rdata_d = out_q;
                OFF_CONTROL: begin
                    rdata_d[CTRL_START_BIT] = req_q;
                    rdata_d[CTRL_DIR_BIT] = dir_q;
                    rdata_d[CTRL_FUNC_LSB +: CTRL_FUNC_W] = func_q;
                    rdata_d[CTRL_DEV_LSB +: CTRL_DEV_W] = dev_q;
                end
                OFF_STATUS: begin
                    rdata_d[STAT_ERROR_BIT] = err_q;
                    rdata_d[STAT_DONE_BIT] = done_q;
                end
                OFF_IRQ_STATUS: rdata_d[EVT_W-1:0] = istat;
                OFF_IRQ_MASK: rdata_d[EVT_W-1:0] = mask_q;
                default: rdata_d = 32'h0;
            endcase
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign mgmt_req_o = req_q;
    assign transfer_direction_o = dir_q;
    assign function_o = func_q;
    assign device_o = dev_q;
    assign config_output_data_o = out_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_q);

    sequence s_bus_req;
        (avs_read_i || avs_write_i) && wait_q && (bus_q == BUS_IDLE);
    endsequence

    sequence s_bus_ans;
        !wait_q ##1 wait_q;
    endsequence

    a_bus_answer: assert property (s_bus_req |=> s_bus_ans)
        else $error("bus answer not in one cycle");

    a_start_request: assert property (start_wr |=> req_q)
        else $error("start write did not raise request");

    a_req_holds: assert property (req_q && !mgmt_ack_i && !start_wr
        |=> req_q)
        else $error("request dropped without ack");

    a_dir_follows: assert property (wr_ctrl && avs_byteenable_i[3]
        |=> dir_q == $past(avs_writedata_i[30]))
        else $error("direction not taken from write");

    a_func_follows: assert property (wr_ctrl && (&avs_byteenable_i[3:2])
        |=> function_o == $past(avs_writedata_i[25:20]))
        else $error("function field wrong");

    a_dev_follows: assert property (wr_ctrl && (&avs_byteenable_i[1:0])
        |=> device_o == $past(avs_writedata_i[11:0]))
        else $error("device field wrong");

    a_stat_readonly: assert property (wr_stat && !mgmt_done_i
        |=> $stable(done_q) && $stable(err_q))
        else $error("status changed by write");

    a_ctrl_clears: assert property (wr_ctrl && !mgmt_done_i
        |=> !done_q && !err_q)
        else $error("control write did not clear flags");

    a_fail_sets_err: assert property (mgmt_done_i && mgmt_fail_i
        |=> err_q && done_q)
        else $error("failure not flagged");

    a_done_sets: assert property (mgmt_done_i
        |=> done_q ##1 (done_q || $past(wr_ctrl)))
        else $error("complete flag not set");

    a_rtn_stable: assert property (!mgmt_rdata_we_i |=> $stable(rtn_q))
        else $error("return data changed without controller");

    a_out_stable: assert property (!wr_out |=> $stable(out_q))
        else $error("output data changed without write");

    a_ok_no_err: assert property (mgmt_done_i && !mgmt_fail_i && !err_q
        |=> !err_q)
        else $error("error set on success");

endmodule

// ===== verilog/cfg_xfer_pkg.sv
// Constants, offsets and types for the board configuration transfer registers
package cfg_xfer_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned BE_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [4:0] OFF_RETURN_DATA = 5'h00;
    localparam logic [4:0] OFF_OUTPUT_DATA = 5'h04;
    localparam logic [4:0] OFF_CONTROL = 5'h08;
    localparam logic [4:0] OFF_STATUS = 5'h0c;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h10;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h14;

    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int unsigned CTRL_START_BIT = 31;
    localparam int unsigned CTRL_DIR_BIT = 30;
    localparam int unsigned CTRL_FUNC_LSB = 20;
    localparam int unsigned CTRL_FUNC_W = 6;
    localparam int unsigned CTRL_DEV_LSB = 0;
    localparam int unsigned CTRL_DEV_W = 12;
    localparam logic DIR_READ = 1'b0;
    localparam logic DIR_WRITE = 1'b1;
    localparam logic [5:0] FUNC_CLOCK_GEN = 6'h01;
    localparam logic [11:0] DEV_CLOCK_GEN0 = 12'h000;
    localparam logic [11:0] DEV_CLOCK_GEN1 = 12'h001;
    localparam logic [11:0] DEV_CLOCK_GEN2 = 12'h002;

    ////////////////////////////////////////////////////////////////////////
    // Status register fields
    localparam int unsigned STAT_ERROR_BIT = 1;
    localparam int unsigned STAT_DONE_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events
    localparam int unsigned EVT_W = 2;
    localparam int unsigned EVT_DONE = 0;
    localparam int unsigned EVT_ERROR = 1;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic DIR_RST = 1'b0;
    localparam logic [5:0] FUNC_RST = 6'h00;
    localparam logic [11:0] DEV_RST = 12'h000;
    localparam logic [1:0] EVT_RST = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Bus answer states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_t;

endpackage

// ===== verilog/irq_event_bank.sv
// Sticky event flags, write-one-to-clear, masked onto one interrupt level
`timescale 1ns/1ps
module irq_event_bank (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Events and software access
    input wire logic [cfg_xfer_pkg::EVT_W-1:0] evt_i,
    input wire logic [cfg_xfer_pkg::EVT_W-1:0] clr_i,
    input wire logic [cfg_xfer_pkg::EVT_W-1:0] mask_i,
    // State
    output logic [cfg_xfer_pkg::EVT_W-1:0] status_o,
    output logic irq_o
);
    import cfg_xfer_pkg::*;

    logic [EVT_W-1:0] stat_q;
    logic [EVT_W-1:0] stat_d;
    logic irq_q;
    logic irq_d;

    // Set wins over a clear in the same cycle
    always_comb begin
        stat_d = (stat_q & ~clr_i) | evt_i;
        irq_d = |(stat_d & mask_i);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_q <= EVT_RST;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q <= irq_d;
        end
    end

    assign status_o = stat_q;
    assign irq_o = irq_q;

    a_evt_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (|evt_i) |=> ((stat_q & $past(evt_i)) == $past(evt_i)))
        else $error("event flag not set");

endmodule
